// ---- tmr_timer.sv ----
// Five 16-bit timer channels with an Avalon-MM register slave.
// Assumes pins are synchronous to i_clk_sys and one bus master.
//
// Summary of operation
// - Every channel holds a sixteen-bit counter.
// - Each channel runs as interval timer, event counter, one-shot or PWM.
// - Timer mode counts the internal source, optionally toggling output or gated by pin.
// - Event mode counts pin edges or neighbour overflows; free-run and toggle selectable.
// - Two-phase input counts up or down by phase, normal or times four.
// - One-shot starts on pin, overflow or software trigger and stops at zero.
// - PWM repeats pulses, fixed 16-bit or variable 8-bit period, triggered like one-shot.
// - Internal source is main clock over 1, 8, 32 or sub clock over 32.
// - Timer and 8-bit PWM periods last programmed value plus one source cycles.
// - Event down period is value plus one; up is all-ones minus value plus one.
// - One-shot lasts the programmed number of source cycles; a value of zero lasts one.
// - Reaching the period raises overflow or underflow and an interrupt request.
// - Pulse output drives the pin directly; no port data register is touched.
// - Count reads give the live count in timer and event modes.
// - Count writes while running update reload only; stopped, both.
// - Enabled timer output drives the pin whatever the port direction, except in event mode with pin direction or two-phase input.
// - Each channel has an input and output pin; event mode reads the output pin.
// - Start flag one counts; zero stops and holds the count.
// - Underflow with reload loads the reload value, continues and sets request.
// - Clearing start with pulse output stops counting and drives the pin low.
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_timer #(
  parameter int NCH = `TMR_NCH
) (
  input  wire logic           i_clk_sys,              // System clock, 10 MHz
  input  wire logic           i_rst_b,                // Async reset, active low
  input  wire logic           i_sub_clk,              // Secondary clock level
  input  wire logic [7:0]     i_avs_address,          // Byte address
  input  wire logic           i_avs_read,             // Read request
  input  wire logic           i_avs_write,            // Write request
  input  wire logic [31:0]    i_avs_writedata,        // Write data
  input  wire logic [3:0]     i_avs_byteenable,       // Byte lanes
  output logic      [31:0]    o_avs_readdata,         // Read data
  output logic                o_avs_waitrequest,      // Stall
  input  wire logic [NCH-1:0] i_timer_input_pin,      // Timer input pins
  input  wire logic [NCH-1:0] i_timer_output_pin,     // Output pin level seen
  output logic      [NCH-1:0] o_timer_output_pin,     // Output pin drive value
  output logic      [NCH-1:0] o_timer_output_pin_oe,  // Output pin enable
  output logic      [NCH-1:0] o_irq_req               // Interrupt request bits
);

  tmr_pkg::tmr_top_type q;
  tmr_pkg::tmr_top_type n;
  logic [3:0]           pre_en;
  logic [NCH-1:0]       tick;
  logic [NCH-1:0]       wr_cnt;
  logic                 wr_ok;

  // ==================================================================
  // Count source prescaler
  tmr_prescale #(
    .DIV_MID  (`TMR_DIV_MID),
    .DIV_SLOW (`TMR_DIV_SLOW)
  ) u_pre (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_sub_clk (i_sub_clk),
    .o_en      (pre_en)
  );

  // ==================================================================
  // Next-state logic: bus slave and all channels
  always_comb begin
    tmr_pkg::tmr_chan_type c;
    tmr_pkg::tmr_mode_type md;
    logic [NCH-1:0]        swt;
    logic [31:0]           rd;
    logic [15:0]           top;
    logic [15:0]           wid;
    int                    jj;
    logic                  src;
    logic                  a;
    logic                  b;
    logic                  rise;
    logic                  fall;
    logic                  ev;
    logic                  trg;
    logic                  t;
    logic                  hit;
    logic                  up;
    logic                  pulse;
    c      = q.ch[0];
    md     = tmr_pkg::TMR_MODE_TIMER;
    swt    = '0;
    rd     = 32'h0000_0000;
    top    = 16'h0000;
    wid    = 16'h0000;
    jj     = 0;
    src    = 1'b0;
    a      = 1'b0;
    b      = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    ev     = 1'b0;
    trg    = 1'b0;
    t      = 1'b0;
    hit    = 1'b0;
    up     = 1'b0;
    pulse  = 1'b0;
    n      = q;
    n.ovf  = '0;
    tick   = '0;
    wr_cnt = '0;
    // Every request is answered one cycle after it rises
    n.ack  = (i_avs_read | i_avs_write) & ~q.ack;
    wr_ok  = i_avs_write & q.ack;
    if (wr_ok && i_avs_address == `TMR_ADR_START && i_avs_byteenable[0]) begin
      n.start = i_avs_writedata[NCH-1:0];
    end
    if (wr_ok && i_avs_address == `TMR_ADR_SWTRIG && i_avs_byteenable[0]) begin
      swt = i_avs_writedata[NCH-1:0];
    end
    for (int i = 0; i < NCH; i++) begin
      c     = q.ch[i];
      md    = tmr_pkg::tmr_mode_type'(c.ctrl[`TMR_F_MODE +: 2]);
      jj    = (i == 0) ? NCH - 1 : i - 1;
      src   = pre_en[c.ctrl[`TMR_F_CLK +: 2]];
      pulse = c.ctrl[`TMR_F_PULSE];
      a     = i_timer_input_pin[i];
      b     = i_timer_output_pin[i];
      rise  = a & ~c.in_q;
      fall  = ~a & c.in_q;
      hit   = 1'b0;
      t     = 1'b0;
      up    = 1'b0;
      // Event and trigger source selection
      unique case (c.ctrl[`TMR_F_SEL +: 2])
        2'h0: ev = fall;
        2'h1: ev = rise;
        2'h2: ev = q.ovf[jj];
        2'h3: ev = 1'b0;
      endcase
      trg = (c.ctrl[`TMR_F_SEL +: 2] == 2'h3) ? swt[i] : ev;
      unique case (md)
        tmr_pkg::TMR_MODE_TIMER: begin
          // Gate compares the input pin with the selected level
          t   = src & q.start[i] &
                (~c.ctrl[`TMR_F_GATE] | (a == c.ctrl[`TMR_F_GATE_HI]));
          hit = t & (c.cnt == 16'h0000);
          if (t) begin
            c.cnt = hit ? c.rld : c.cnt - 16'h0001;
          end
          if (hit && pulse) begin
            c.out = ~c.out;
          end
        end
        tmr_pkg::TMR_MODE_EVENT: begin
          if (c.ctrl[`TMR_F_TWOPH]) begin
            if (c.ctrl[`TMR_F_X4]) begin
              // Every edge of either phase counts
              t  = q.start[i] & ((a ^ c.in_q) | (b ^ c.aux_q));
              up = a ^ c.aux_q;
            end else begin
              t  = q.start[i] & rise;
              up = ~b;
            end
          end else begin
            t  = q.start[i] & ev;
            up = c.ctrl[`TMR_F_DIRPIN] ? b : c.ctrl[`TMR_F_UP];
          end
          if (t && up) begin
            hit   = (c.cnt == `TMR_CNT_MAX);
            c.cnt = (hit && !c.ctrl[`TMR_F_FREE]) ? c.rld : c.cnt + 16'h0001;
          end else if (t) begin
            hit   = (c.cnt == 16'h0000);
            c.cnt = hit ? (c.ctrl[`TMR_F_FREE] ? `TMR_CNT_MAX : c.rld)
                        : c.cnt - 16'h0001;
          end
          if (hit && pulse) begin
            c.out = ~c.out;
          end
        end
        tmr_pkg::TMR_MODE_ONESHOT: begin
          if (c.st == tmr_pkg::TMR_ST_IDLE) begin
            if (q.start[i] && trg) begin
              c.st  = tmr_pkg::TMR_ST_RUN;
              c.cnt = c.rld;
              c.out = pulse;
            end
          end else begin
            t = src;
            if (t && c.cnt <= 16'h0001) begin
              hit   = 1'b1;
              c.cnt = 16'h0000;
              c.st  = tmr_pkg::TMR_ST_IDLE;
              c.out = 1'b0;
            end else if (t) begin
              c.cnt = c.cnt - 16'h0001;
            end
          end
        end
        tmr_pkg::TMR_MODE_PWM: begin
          // Fixed 16-bit period, or 8-bit width over an 8-bit period
          top = c.ctrl[`TMR_F_PWM8] ? {8'h00, c.rld[7:0]} : `TMR_PWM16_TOP;
          wid = c.ctrl[`TMR_F_PWM8] ? {8'h00, c.rld[15:8]} : c.rld;
          if (c.st == tmr_pkg::TMR_ST_IDLE) begin
            if (q.start[i] && trg) begin
              c.st  = tmr_pkg::TMR_ST_RUN;
              c.ph  = 16'h0000;
              c.out = pulse & (wid != 16'h0000);
            end
          end else begin
            t = src;
            if (t) begin
              hit   = (c.ph == top);
              c.ph  = hit ? 16'h0000 : c.ph + 16'h0001;
              c.out = pulse & (c.ph < wid);
            end
          end
        end
      endcase
      // Stopping holds the count and parks the pulse output low
      if (!q.start[i]) begin
        c.st = tmr_pkg::TMR_ST_IDLE;
        if (pulse) begin
          c.out = 1'b0;
        end
      end
      // Control register write, byte lanes honoured
      if (wr_ok && i_avs_address == {4'(i), `TMR_OFS_CTRL}) begin
        if (i_avs_byteenable[0]) begin
          c.ctrl[7:0] = i_avs_writedata[7:0];
        end
        if (i_avs_byteenable[1]) begin
          c.ctrl[15:8] = i_avs_writedata[15:8];
        end
      end
      // Count write takes effect only as one 16-bit access
      wr_cnt[i] = wr_ok && i_avs_address == {4'(i), `TMR_OFS_COUNT} &&
                  i_avs_byteenable[1:0] == 2'h3;
      if (wr_cnt[i]) begin
        c.rld = i_avs_writedata[15:0];
        if (!q.start[i]) begin
          c.cnt = i_avs_writedata[15:0];
        end
      end
      c.in_q   = a;
      c.aux_q  = b;
      n.ch[i]  = c;
      n.ovf[i] = hit;
      tick[i]  = t;
    end
    // Request bits: a new overflow wins over a clear in the same cycle
    if (wr_ok && i_avs_address == `TMR_ADR_IRQ && i_avs_byteenable[0]) begin
      n.irq = q.irq & ~i_avs_writedata[NCH-1:0];
    end
    n.irq = n.irq | n.ovf;
    // Read decode, registered on the request cycle
    if (i_avs_address == `TMR_ADR_START) begin
      rd[NCH-1:0] = q.start;
    end else if (i_avs_address == `TMR_ADR_IRQ) begin
      rd[NCH-1:0] = q.irq;
    end
    for (int i = 0; i < NCH; i++) begin
      if (i_avs_address == {4'(i), `TMR_OFS_CTRL}) begin
        rd[15:0] = q.ch[i].ctrl;
      end
      if (i_avs_address == {4'(i), `TMR_OFS_COUNT}) begin
        rd[15:0] = q.ch[i].cnt;
      end
    end
    if (i_avs_read && !q.ack) begin
      n.rdata = rd;
    end
  end

  // ==================================================================
  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==================================================================
  // Outputs
  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~q.ack;
  assign o_irq_req         = q.irq;

  // Pin driven from the channel flop; no port data register involved
  for (genvar g = 0; g < NCH; g++) begin : g_pin
    assign o_timer_output_pin[g]    = q.ch[g].out;
    assign o_timer_output_pin_oe[g] = q.ch[g].ctrl[`TMR_F_PULSE] &
      ~((q.ch[g].ctrl[`TMR_F_MODE +: 2] == 2'h1) &
        (q.ch[g].ctrl[`TMR_F_DIRPIN] | q.ch[g].ctrl[`TMR_F_TWOPH]));
  end

  // ==================================================================
  // Assertions on channel 0
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_tmr_under;
    q.ch[0].ctrl[1:0] == 2'h0 && q.start[0] && tick[0] && q.ch[0].cnt == 16'h0000;
  endsequence

  sequence s_os_last;
    q.ch[0].ctrl[1:0] == 2'h2 && q.start[0] && q.ch[0].st == tmr_pkg::TMR_ST_RUN &&
    tick[0] && q.ch[0].cnt <= 16'h0001;
  endsequence

  a_timer_reload_irq: assert property (
    s_tmr_under |=> q.ch[0].cnt == $past(q.ch[0].rld) && q.irq[0])
    else $error("timer underflow did not reload or raise request");

  a_timer_count_down: assert property (
    q.ch[0].ctrl[1:0] == 2'h0 && tick[0] && q.ch[0].cnt != 16'h0000
    |=> q.ch[0].cnt == $past(q.ch[0].cnt) - 16'h0001)
    else $error("timer did not count down by one");

  a_stop_hold_count: assert property (
    !q.start[0] && !wr_cnt[0] |=> $stable(q.ch[0].cnt))
    else $error("stopped counter changed");

  a_pulse_toggle_out: assert property (
    s_tmr_under ##0 q.ch[0].ctrl[4] |=> o_timer_output_pin[0] != $past(o_timer_output_pin[0]))
    else $error("pulse output did not toggle on underflow");

  a_gate_hold_count: assert property (
    q.ch[0].ctrl[1:0] == 2'h0 && q.ch[0].ctrl[5] &&
    i_timer_input_pin[0] != q.ch[0].ctrl[6] && !wr_cnt[0] |=> $stable(q.ch[0].cnt))
    else $error("gated timer counted while gate closed");

  a_free_run_wrap: assert property (
    q.ch[0].ctrl[1:0] == 2'h1 && q.ch[0].ctrl[7] && q.ch[0].ctrl[11:8] == 4'h0 &&
    tick[0] && q.ch[0].cnt == 16'h0000 && !wr_cnt[0] |=> q.ch[0].cnt == 16'hffff)
    else $error("free-run counter did not wrap");

  a_write_stopped_both: assert property (
    wr_cnt[0] && !q.start[0]
    |=> q.ch[0].cnt == $past(i_avs_writedata[15:0]) && q.ch[0].rld == q.ch[0].cnt)
    else $error("stopped write did not load counter and reload");

  a_write_running_rld: assert property (
    wr_cnt[0] && q.start[0] |=> q.ch[0].rld == $past(i_avs_writedata[15:0]))
    else $error("running write did not load reload");

  a_stop_out_low: assert property (
    q.ch[0].ctrl[4] && !q.start[0] |=> !o_timer_output_pin[0] [*1])
    else $error("output not low after stop");

  a_oneshot_end_zero: assert property (
    s_os_last |=> q.ch[0].st == tmr_pkg::TMR_ST_IDLE && q.ch[0].cnt == 16'h0000 ##1 q.irq[0])
    else $error("one-shot did not end at zero with request");

endmodule

// ---- tmr_map.svh ----
// Constants for the five-channel timer: register offsets, field positions,
// reset values and divider ratios.
// Assumes inclusion by bare name from the package and from the design files.
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ==================================================================
// Channel count and register map (byte addresses)
`define TMR_NCH         5
`define TMR_CH_SHIFT    4
`define TMR_OFS_CTRL    4'h0
`define TMR_OFS_COUNT   4'h4
`define TMR_ADR_START   8'h50
`define TMR_ADR_SWTRIG  8'h54
`define TMR_ADR_IRQ     8'h58

// ==================================================================
// Control register field positions
`define TMR_F_MODE      0
`define TMR_F_CLK       2
`define TMR_F_PULSE     4
`define TMR_F_GATE      5
`define TMR_F_GATE_HI   6
`define TMR_F_FREE      7
`define TMR_F_UP        8
`define TMR_F_DIRPIN    9
`define TMR_F_TWOPH     10
`define TMR_F_X4        11
`define TMR_F_SEL       12
`define TMR_F_PWM8      14

// ==================================================================
// Reset values, count limits and divider ratios
`define TMR_RST_CTRL    16'h0000
`define TMR_RST_COUNT   16'h0000
`define TMR_CNT_MAX     16'hffff
`define TMR_PWM16_TOP   16'hfffe
`define TMR_DIV_MID     8
`define TMR_DIV_SLOW    32

`endif

// ---- tmr_pkg.sv ----
// Types shared by the timer block: modes, channel run state, register images.
// Assumes tmr_map.svh is on the include path.
`include "tmr_map.svh"

package tmr_pkg;

  // ==================================================================
  // Modes and channel run state
  typedef enum logic [1:0] {
    TMR_MODE_TIMER,
    TMR_MODE_EVENT,
    TMR_MODE_ONESHOT,
    TMR_MODE_PWM
  } tmr_mode_type;

  typedef enum logic {
    TMR_ST_IDLE,
    TMR_ST_RUN
  } tmr_run_type;

  // ==================================================================
  // State of one channel
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] ph;
    tmr_run_type st;
    logic        out;
    logic        in_q;
    logic        aux_q;
  } tmr_chan_type;

  // State of the whole block
  typedef struct packed {
    tmr_chan_type [`TMR_NCH-1:0] ch;
    logic [`TMR_NCH-1:0]         start;
    logic [`TMR_NCH-1:0]         irq;
    logic [`TMR_NCH-1:0]         ovf;
    logic                        ack;
    logic [31:0]                 rdata;
  } tmr_top_type;

  // State of the prescaler
  typedef struct packed {
    logic [4:0] c_mid;
    logic [4:0] c_slow;
    logic [4:0] c_sub;
    logic       sub_q;
    logic [3:0] en;
  } tmr_pre_type;

endpackage

// ---- tmr_prescale.sv ----
// Prescaler: one-cycle enables for main clock /1, /8, /32 and sub clock /32.
// Assumes the sub clock input is a slow level sampled on the system clock.
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_prescale #(
  parameter int DIV_MID  = `TMR_DIV_MID,
  parameter int DIV_SLOW = `TMR_DIV_SLOW
) (
  input  wire logic       i_clk_sys,  // System clock
  input  wire logic       i_rst_b,    // Async reset, active low
  input  wire logic       i_sub_clk,  // Secondary clock level
  output logic      [3:0] o_en        // Enables: div1, div8, div32, sub32
);

  tmr_pkg::tmr_pre_type q;
  tmr_pkg::tmr_pre_type n;

  // ==================================================================
  // Divider counters and enable generation
  always_comb begin
    n       = q;
    n.sub_q = i_sub_clk;
    n.en    = 4'h1;
    n.c_mid = (q.c_mid == 5'(DIV_MID - 1)) ? 5'h00 : q.c_mid + 5'h01;
    n.c_slow = (q.c_slow == 5'(DIV_SLOW - 1)) ? 5'h00 : q.c_slow + 5'h01;
    if (q.c_mid == 5'(DIV_MID - 1)) begin
      n.en[1] = 1'b1;
    end
    if (q.c_slow == 5'(DIV_SLOW - 1)) begin
      n.en[2] = 1'b1;
    end
    // Sub clock rising edges counted on the system clock
    if (i_sub_clk && !q.sub_q) begin
      n.c_sub = (q.c_sub == 5'(DIV_SLOW - 1)) ? 5'h00 : q.c_sub + 5'h01;
      n.en[3] = (q.c_sub == 5'(DIV_SLOW - 1));
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_en = q.en;  // Registered enables

endmodule

// ---- tmr_pins_model.sv ----
// Far-side model of the timer pins: pulse source on the input pins and
// pull-up resolution of the output pins.
// Assumes the bench calls send_pulses right after a rising clock edge.
`timescale 1ns/1ps

module tmr_pins_model #(
  parameter int NCH = 5
) (
  input  wire logic           i_clk_sys,  // System clock
  input  wire logic [NCH-1:0] i_drv,      // Output pin drive value
  input  wire logic [NCH-1:0] i_oe,       // Output pin enable
  output logic      [NCH-1:0] o_in_pin,   // Timer input pins
  output logic      [NCH-1:0] o_seen      // Resolved output pin level
);
  // ==================================================================
  // Output pins: pulled up whenever the timer does not drive them
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      o_seen[i] = i_oe[i] ? i_drv[i] : 1'b1;
    end
  end

  // Input pins idle low
  initial o_in_pin = '0;

  // Pulse train, each level held for two clock cycles
  task automatic send_pulses(input int ch, input int n);
    for (int k = 0; k < n; k++) begin
      o_in_pin[ch] <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_in_pin[ch] <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
endmodule

// ---- tmr_tb.sv ----
// Self-checking bench for the five-channel timer, channel 0 exercised.
// Assumes tmr_map.svh on the include path and the pins model beside it.
`timescale 1ns/1ps
`include "tmr_map.svh"

module testbench;
  localparam logic [7:0] A_CTL = 8'h00;
  localparam logic [7:0] A_CNT = 8'h04;
  localparam logic [7:0] A_RST [4] = '{8'h00, 8'h04, 8'h58, 8'h5c};
  logic        clk;
  logic        rst_b;
  logic        sub_clk = 1'b0;
  logic        rd;
  logic        wr;
  logic [7:0]  adr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  logic [4:0]  in_pin;
  logic [4:0]  seen;
  logic [4:0]  drv;
  logic [4:0]  oe;
  logic [4:0]  irq;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] q2;
  int          fail_count;
  int          checks;
  int          n;
  int          m;
  int          c;

  tmr_timer DUT (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_sub_clk(sub_clk), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_timer_input_pin(in_pin),
    .i_timer_output_pin(seen), .o_timer_output_pin(drv), .o_timer_output_pin_oe(oe),
    .o_irq_req(irq));

  tmr_pins_model pins (
    .i_clk_sys(clk), .i_drv(drv), .i_oe(oe), .o_in_pin(in_pin), .o_seen(seen));

  // ==================================================================
  // Clock, sub clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Sub clock toggles each cycle: one rising edge every two cycles
  always @(posedge clk) sub_clk <= ~sub_clk;

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    wrap_up();
  end

  // ==================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Cycles per output toggle for a source select and reload
  function automatic int period(input int s, input int v);
    int div;
    div = (s == 0) ? 1 : (s == 1) ? `TMR_DIV_MID : (s == 2) ? `TMR_DIV_SLOW : 2 * `TMR_DIV_SLOW;
    return (v + 1) * div;
  endfunction

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", name, e, g);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 100);
    if (k >= 100) fail_count++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(a, 1'b1, d);
  endtask

  task automatic bus_rd(input logic [7:0] a);
    bus_xfer(a, 1'b0, 32'h0000_0000);
  endtask

  // Cycles between the first and second change of output pin 0
  task automatic measure(output int cyc);
    logic last;
    cyc = 0;
    @(negedge clk);
    last = seen[0];
    while (seen[0] === last && cyc < 9000) begin
      @(negedge clk);
      cyc++;
    end
    last = seen[0];
    cyc = 0;
    while (seen[0] === last && cyc < 9000) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wdata = 32'h0000_0000;
    seed = 32'h9f22;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place included
    foreach (A_RST[i]) begin
      bus_rd(A_RST[i]);
      chk("reset_value", 32'h0000_0000, q);
    end
    // Interval timer with pulse output on every source
    for (int s = 0; s < 4; s++) begin
      n = (s == 0) ? 2 + rnd() % 20 : 1 + rnd() % 3;
      bus_wr(A_CTL, 32'h10 | (s << 2));
      bus_wr(A_CNT, n);
      bus_rd(A_CNT);
      chk("count_load", n, q);
      bus_wr(`TMR_ADR_START, 32'h1);
      measure(c);
      chk("period", period(s, n), c);
      chk("pin_enable", 1, oe[0]);
      if (s == 0) begin
        m = 2 + rnd() % 20;
        bus_wr(A_CNT, m);
        // First interval may still run on the old reload value
        measure(c);
        measure(c);
        chk("reload_only", m + 1, c);
      end
      chk("irq_pin", 1, irq[0]);
      bus_wr(`TMR_ADR_START, 32'h0);
      bus_rd(A_CNT);
      q2 = q;
      repeat (20) @(posedge clk);
      bus_rd(A_CNT);
      chk("hold", q2, q);
      chk("stop_low", 0, seen[0]);
      bus_wr(`TMR_ADR_IRQ, 32'h1);
      bus_rd(`TMR_ADR_IRQ);
      chk("irq_clear", 0, q);
    end
    // Gated timer: counts only while the input pin is high
    m = 100 + rnd() % 900;
    n = 1 + rnd() % 8;
    bus_wr(A_CTL, 32'h60);
    bus_wr(A_CNT, m);
    bus_wr(`TMR_ADR_START, 32'h1);
    repeat (10) @(posedge clk);
    bus_rd(A_CNT);
    chk("gate_closed", m, q);
    pins.send_pulses(0, n);
    bus_rd(A_CNT);
    chk("gate_open", m - 2 * n, q);
    bus_wr(`TMR_ADR_START, 32'h0);
    // Event counter, down then up, on input rising edges
    for (int up = 0; up < 2; up++) begin
      m = 100 + rnd() % 900;
      n = 1 + rnd() % 8;
      bus_wr(A_CTL, 32'h1001 | (up << 8));
      bus_wr(A_CNT, m);
      bus_wr(`TMR_ADR_START, 32'h1);
      pins.send_pulses(0, n);
      repeat (4) @(posedge clk);
      bus_rd(A_CNT);
      chk("event_count", up ? m + n : m - n, q);
      bus_wr(`TMR_ADR_START, 32'h0);
    end
    // Free-running down count wraps through all-ones instead of reloading
    n = 2 + rnd() % 7;
    bus_wr(A_CTL, 32'h1081);
    bus_wr(A_CNT, 32'h1);
    bus_wr(`TMR_ADR_START, 32'h1);
    pins.send_pulses(0, n);
    repeat (4) @(posedge clk);
    bus_rd(A_CNT);
    chk("free_run", (32'h1_0001 - n) & 32'hffff, q);
    chk("free_irq", 1, irq[0]);
    bus_wr(`TMR_ADR_START, 32'h0);
    bus_wr(`TMR_ADR_IRQ, 32'h1);
    // One-shot on a software trigger
    n = 2 + rnd() % 20;
    bus_wr(A_CTL, 32'h3012);
    bus_wr(A_CNT, n);
    bus_wr(`TMR_ADR_START, 32'h1);
    fork
      measure(c);
      bus_wr(`TMR_ADR_SWTRIG, 32'h1);
    join
    chk("oneshot_width", n, c);
    bus_rd(`TMR_ADR_IRQ);
    chk("oneshot_irq", 1, q[0]);
    // Eight-bit PWM: high for the high byte, period of low byte plus one
    n = 1 + rnd() % 6;
    m = n + rnd() % 8;
    bus_wr(`TMR_ADR_START, 32'h0);
    bus_wr(A_CTL, 32'h7013);
    bus_wr(A_CNT, (n << 8) | m);
    bus_wr(`TMR_ADR_START, 32'h1);
    fork
      measure(c);
      bus_wr(`TMR_ADR_SWTRIG, 32'h1);
    join
    chk("pwm_high", n, c);
    c = 0;
    while (seen[0] === 1'b0 && c < 9000) begin
      @(negedge clk);
      c++;
    end
    chk("pwm_low", m + 1 - n, c);
    wrap_up();
  end

endmodule
